// File: rtl/assd_pkg.sv
package assd_pkg;
    // Word index of each register; the byte address is four times the index
    localparam logic [7:0] IDX_STATUS_ONE   = 8'h16;
    localparam logic [7:0] IDX_STATUS_TWO   = 8'h17;
    localparam logic [7:0] IDX_DATA_BUFFER  = 8'h18;
    localparam logic [7:0] IDX_CONTROL_TWO  = 8'h14;
    localparam logic [7:0] IDX_CONTROL_THREE = 8'h15;
    localparam logic [7:0] IDX_CONTROL_ONE  = 8'h13;

    // Status one bit positions
    localparam int ST1_TX_EMPTY    = 7;
    localparam int ST1_TX_COMPLETE = 6;
    localparam int ST1_RX_FULL     = 5;
    localparam int ST1_IDLE        = 4;
    localparam int ST1_OVERRUN     = 3;
    localparam int ST1_NOISE       = 2;
    localparam int ST1_FRAMING     = 1;
    localparam int ST1_PARITY      = 0;
    // Status two bit positions
    localparam int ST2_BREAK       = 1;
    localparam int ST2_PROGRESS    = 0;
    // Control two bit positions
    localparam int CT2_TXE_IE      = 7;
    localparam int CT2_TC_IE       = 6;
    localparam int CT2_RXF_IE      = 5;
    localparam int CT2_IDLE_IE     = 4;
    // Control three bit positions
    localparam int CT3_RX_NINTH    = 7;
    localparam int CT3_TX_NINTH    = 6;
    localparam int CT3_OVR_IE      = 3;
    localparam int CT3_NOISE_IE    = 2;
    localparam int CT3_FRAME_IE    = 1;
    localparam int CT3_PARITY_IE   = 0;
    // Control one bit position
    localparam int CT1_NINE_BIT    = 4;

    localparam logic [7:0] CT2_RESET = 8'h00;
    localparam logic [3:0] CT3_IE_RESET = 4'h0;
    localparam logic [7:0] CT1_RESET = 8'h00;
    localparam logic [7:0] WB_UNMAPPED = 8'h00;
    localparam logic [3:0] IDLE_LEN_8BIT = 4'hA;
    localparam logic [3:0] IDLE_LEN_9BIT = 4'hB;

    typedef enum logic [2:0] {
        ASSD_CLR_IDLE  = 3'b001,
        ASSD_CLR_ARMED = 3'b010,
        ASSD_CLR_DONE  = 3'b100
    } assd_clr_state_t;
endpackage

// File: rtl/assd_ev_if.sv
`timescale 1ns/10ps
interface assd_ev_if;
    logic status_read;
    logic data_read;
    logic [7:0] flags_at_read;
    logic [7:0] clear_mask;
    modport seq (input status_read, input data_read, input flags_at_read, output clear_mask);
    modport user (output status_read, output data_read, output flags_at_read, input clear_mask);
endinterface

// File: rtl/assd_clear_seq.sv
`timescale 1ns/10ps
module assd_clear_seq
    import assd_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst_n,
    assd_ev_if.seq   ev
);
    // Remembers which flags were seen set by a status read; a later
    // data read clears exactly those, so a flag raised in between survives.
    logic [7:0] armed_q;
    logic [7:0] armed_d;

    always_comb begin
        armed_d       = armed_q;
        ev.clear_mask = 8'h00;
        if (ev.data_read) begin
            ev.clear_mask = armed_q;
            armed_d       = 8'h00;
        end
        if (ev.status_read) begin
            armed_d = ev.flags_at_read;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            armed_q <= 8'h00;
        end else begin
            armed_q <= armed_d;
        end
    end
endmodule

// File: rtl/assd_idle_det.sv
`timescale 1ns/10ps
module assd_idle_det
    import assd_pkg::*;
(
    input  wire logic sys_clk,
    input  wire logic rst_n,
    input  wire logic bit_tick,
    input  wire logic rx_bit,
    input  wire logic nine_bit,
    output logic      idle_seen
);
    // Counts sampled ones on the receiver input at bit rate
    logic [3:0] ones_q;
    logic [3:0] ones_d;
    logic [3:0] need;

    always_comb begin
        need      = nine_bit ? IDLE_LEN_9BIT : IDLE_LEN_8BIT;
        ones_d    = ones_q;
        idle_seen = 1'b0;
        if (bit_tick) begin
            if (!rx_bit) begin
                ones_d = 4'h0;
            end else if (ones_q == need - 4'h1) begin
                ones_d    = 4'h0;
                idle_seen = 1'b1;
            end else begin
                ones_d = ones_q + 4'h1;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            ones_q <= 4'h0;
        end else begin
            ones_q <= ones_d;
        end
    end
endmodule

// File: rtl/assd_top.sv
`timescale 1ns/10ps
// Operation
// [RULE_01] 9-bit mode: received ninth bit captured with data; reset leaves it.
// [RULE_02] 8-bit mode: rx ninth bit mirrors received bit 7.
// [RULE_03] 9-bit mode: tx ninth bit goes to shifter with data; reset-free.
// [RULE_04] Four error enables; reset clears noise, framing and parity enables.
// [RULE_05] Tx-empty set on handoff and reset; status read then data write clears.
// [RULE_06] Tx interrupt while tx-empty and its enable are both set.
// [RULE_07] Tx-complete set when empty and idle; cleared when output queued.
// [RULE_08] Tx-complete requests tx interrupt if enabled; reset sets it.
// [RULE_09] Rx-full set on load, interrupts if enabled, status-then-data clears.
// [RULE_10] Idle set after 10 or 11 consecutive ones per character length.
// [RULE_11] Idle arms only after a valid character set rx-full.
// [RULE_12] Idle interrupts if enabled; status-then-data read clears; reset clears.
// [RULE_13] New character while rx-full: overrun set, character dropped, buffer kept.
// [RULE_14] Overrun clears only if set at the preceding status read.
// [RULE_15] Noise flag set on noise, interrupts if enabled, read sequence clears.
// [RULE_16] Framing flag set on zero stop bit, interrupts if enabled, clears likewise.
// [RULE_17] Parity flag set on parity fail, interrupts if enabled, clears likewise.
// [RULE_18] Break sets break, framing, rx-full; clears rx ninth bit; no interrupt. Code clears the ninth bit in 9-bit mode only.
// [RULE_19] Break clears via status two then data read; rearms after ones.
// [RULE_20] Progress flag set at first sample slot zero; reset by false start or idle.
// [RULE_21] Data buffer read gives received byte, write gives tx byte; reset-free.
// [RULE_22] Software avoids read-modify-write on the data buffer.
// [RULE_23] Character-length bit: 0 eight-bit, 1 nine-bit characters.
// [RULE_24] Gated error requests combine into one error interrupt line.
module assd_top
    import assd_pkg::*;
(
    input  wire logic        sys_clk,
    input  wire logic        rst_n,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [9:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic [31:0]      wb_dat_o,
    output logic             wb_ack_o,
    input  wire logic        rx_char_done,
    input  wire logic [8:0]  rx_char,
    input  wire logic        rx_noise,
    input  wire logic        rx_stop_zero,
    input  wire logic        rx_parity_fail,
    input  wire logic        rx_break,
    input  wire logic        rx_enable_rise,
    input  wire logic        rx_first_slot_zero,
    input  wire logic        rx_false_start,
    input  wire logic        rx_bit_tick,
    input  wire logic        receive_pin,
    input  wire logic        tx_load_ready,
    input  wire logic        tx_busy,
    input  wire logic        tx_queued,
    output logic             tx_load,
    output logic [8:0]       tx_char,
    output logic             nine_bit_mode,
    output logic             tx_irq,
    output logic             rx_irq,
    output logic             err_irq
);
    import assd_pkg::*;

    logic [7:0]  rx_buf_q, rx_buf_d, tx_buf_q, tx_buf_d;
    logic        rx_ninth_bit_q, rx_ninth_bit_d, tx_ninth_bit_q, tx_ninth_bit_d;
    logic        tx_pending_q, tx_pending_d;
    logic [7:0]  st1_q, st1_d;
    logic        break_flag_q, break_flag_d;
    logic        break_armed_q, break_armed_d;
    logic        rx_progress_flag_q, rx_progress_flag_d;
    logic        idle_armed_q, idle_armed_d;
    logic [7:0]  ct1_q, ct1_d, ct2_q, ct2_d;
    logic [3:0]  err_ie_q, err_ie_d;
    logic        ack_q, ack_d;
    logic [31:0] rdat_q, rdat_d;
    logic        idle_seen;
    logic        req;
    logic [7:0]  idx;
    logic [7:0]  clr1, clr2;

    assd_ev_if ev1 ();
    assd_ev_if ev2 ();

    assd_clear_seq u_clr1 (
        .sys_clk (sys_clk),
        .rst_n   (rst_n),
        .ev      (ev1.seq)
    );

    assd_clear_seq u_clr2 (
        .sys_clk (sys_clk),
        .rst_n   (rst_n),
        .ev      (ev2.seq)
    );

    assd_idle_det u_idle (
        .sys_clk   (sys_clk),
        .rst_n     (rst_n),
        .bit_tick  (rx_bit_tick),
        .rx_bit    (receive_pin),
        .nine_bit  (ct1_q[CT1_NINE_BIT]),
        .idle_seen (idle_seen)
    );

    function automatic logic hit(input logic [7:0] a, input logic [7:0] b);
        return a == b;
    endfunction

    // Ack drops for one cycle between accesses
    assign req   = wb_cyc_i && wb_stb_i && !ack_q;
    assign idx   = wb_adr_i[9:2];
    assign clr1  = ev1.clear_mask;
    assign clr2  = ev2.clear_mask;

    assign ev1.status_read   = req && !wb_we_i && wb_sel_i[0] && hit(idx, IDX_STATUS_ONE);
    assign ev1.data_read     = req && wb_sel_i[0] && hit(idx, IDX_DATA_BUFFER);
    assign ev1.flags_at_read = st1_q;
    assign ev2.status_read   = req && !wb_we_i && wb_sel_i[0] && hit(idx, IDX_STATUS_TWO);
    assign ev2.data_read     = req && !wb_we_i && wb_sel_i[0] && hit(idx, IDX_DATA_BUFFER);
    assign ev2.flags_at_read = {6'h00, break_flag_q, 1'b0};

    assign nine_bit_mode = ct1_q[CT1_NINE_BIT];            // see [RULE_23]
    assign tx_irq = (st1_q[ST1_TX_EMPTY] && ct2_q[CT2_TXE_IE])            // see [RULE_06]
                  || (st1_q[ST1_TX_COMPLETE] && ct2_q[CT2_TC_IE]);        // see [RULE_08]
    assign rx_irq = (st1_q[ST1_RX_FULL] && ct2_q[CT2_RXF_IE])             // see [RULE_09]
                  || (st1_q[ST1_IDLE] && ct2_q[CT2_IDLE_IE]);             // see [RULE_12]
    assign err_irq = |(st1_q[3:0] & err_ie_q);             // see [RULE_24]
    assign wb_ack_o = ack_q;
    assign wb_dat_o = rdat_q;
    assign tx_load  = tx_pending_q && tx_load_ready;
    assign tx_char  = {tx_ninth_bit_q, tx_buf_q};

    always_comb begin
        logic wr0;
        logic dwrite;
        logic take;
        wr0     = req && wb_we_i && wb_sel_i[0];
        dwrite  = wr0 && hit(idx, IDX_DATA_BUFFER);
        take    = rx_char_done && !st1_q[ST1_RX_FULL];
        ack_d   = req;
        rdat_d  = 32'h00000000;
        rx_buf_d = rx_buf_q;
        rx_ninth_bit_d = rx_ninth_bit_q;
        tx_buf_d = tx_buf_q;
        tx_ninth_bit_d = tx_ninth_bit_q;
        tx_pending_d = tx_pending_q;
        ct1_d   = ct1_q;
        ct2_d   = ct2_q;
        err_ie_d = err_ie_q;
        idle_armed_d = idle_armed_q;
        break_armed_d = break_armed_q;
        rx_progress_flag_d = rx_progress_flag_q;

        // Clears first, so that sets in the same cycle win
        st1_d = st1_q & ~(clr1 & (wb_we_i ? 8'h00 : 8'h3F));  // see [RULE_14]
        break_flag_d = break_flag_q && !clr2[ST2_BREAK];   // see [RULE_19]

        // Data write clears empty only if armed at status read
        if (dwrite) begin
            tx_buf_d     = wb_dat_i[7:0];                 // see [RULE_21]
            tx_pending_d = 1'b1;
            if (clr1[ST1_TX_EMPTY]) begin
                st1_d[ST1_TX_EMPTY] = 1'b0;               // see [RULE_05]
            end
        end
        if (tx_load) begin
            tx_pending_d = 1'b0;
            st1_d[ST1_TX_EMPTY] = 1'b1;                   // see [RULE_05]
        end
        // Queued or busy output holds complete low
        st1_d[ST1_TX_COMPLETE] = st1_d[ST1_TX_EMPTY] && !tx_busy
                                 && !tx_queued && !tx_pending_d && !tx_load;  // see [RULE_07]

        // Receive side
        if (rx_char_done && st1_q[ST1_RX_FULL]) begin
            st1_d[ST1_OVERRUN] = 1'b1;                    // see [RULE_13]
        end
        if (take) begin
            rx_buf_d = rx_char[7:0];
            rx_ninth_bit_d = ct1_q[CT1_NINE_BIT] ? rx_char[8] : rx_char[7];  // see [RULE_01] [RULE_02]
            st1_d[ST1_RX_FULL] = 1'b1;                    // see [RULE_09]
            idle_armed_d = 1'b1;                          // see [RULE_11]
            if (rx_parity_fail) begin
                st1_d[ST1_PARITY] = 1'b1;                 // see [RULE_17]
            end
            if (rx_stop_zero) begin
                st1_d[ST1_FRAMING] = 1'b1;                // see [RULE_16]
            end
        end
        if (rx_noise) begin
            st1_d[ST1_NOISE] = 1'b1;                      // see [RULE_15]
        end
        if (rx_break && break_armed_q) begin
            break_flag_d = 1'b1;                          // see [RULE_18]
            break_armed_d = 1'b0;
            st1_d[ST1_FRAMING] = 1'b1;
            st1_d[ST1_RX_FULL] = 1'b1;
            if (ct1_q[CT1_NINE_BIT]) begin
                rx_ninth_bit_d = 1'b0;
            end
        end
        if (receive_pin && rx_bit_tick) begin
            break_armed_d = 1'b1;                         // see [RULE_19]
        end
        if (clr1[ST1_IDLE] && !wb_we_i && !take) begin
            idle_armed_d = 1'b0;                          // see [RULE_11]
        end
        if (rx_enable_rise) begin
            idle_armed_d = 1'b0;
        end
        if (idle_seen && idle_armed_q) begin
            st1_d[ST1_IDLE] = 1'b1;                       // see [RULE_10] [RULE_12]
        end
        if (rx_false_start || idle_seen) begin
            rx_progress_flag_d = 1'b0;                    // see [RULE_20]
        end
        if (rx_first_slot_zero) begin
            rx_progress_flag_d = 1'b1;                    // see [RULE_20]
        end

        // Register writes and reads
        if (wr0 && hit(idx, IDX_CONTROL_ONE)) begin
            ct1_d = wb_dat_i[7:0];
        end
        if (wr0 && hit(idx, IDX_CONTROL_TWO)) begin
            ct2_d = wb_dat_i[7:0];
        end
        if (wr0 && hit(idx, IDX_CONTROL_THREE)) begin
            tx_ninth_bit_d = wb_dat_i[CT3_TX_NINTH];      // see [RULE_03]
            err_ie_d = wb_dat_i[3:0];                     // see [RULE_04]
        end
        if (req && !wb_we_i) begin
            unique case (1'b1)
                hit(idx, IDX_STATUS_ONE):    rdat_d[7:0] = st1_q;
                hit(idx, IDX_STATUS_TWO):    rdat_d[7:0] = {6'h00, break_flag_q,
                                                            rx_progress_flag_q};
                hit(idx, IDX_DATA_BUFFER):   rdat_d[7:0] = rx_buf_q;  // see [RULE_21]
                hit(idx, IDX_CONTROL_ONE):   rdat_d[7:0] = ct1_q;
                hit(idx, IDX_CONTROL_TWO):   rdat_d[7:0] = ct2_q;
                hit(idx, IDX_CONTROL_THREE): rdat_d[7:0] = {rx_ninth_bit_q, tx_ninth_bit_q,
                                                            2'b00, err_ie_q};
                default:                     rdat_d[7:0] = WB_UNMAPPED;
            endcase
        end
    end

    // Data buffers and ninth bits keep their contents through reset
    always_ff @(posedge sys_clk) begin
        rx_buf_q       <= rx_buf_d;                       // see [RULE_21]
        tx_buf_q       <= tx_buf_d;
        rx_ninth_bit_q <= rx_ninth_bit_d;                 // see [RULE_01]
        tx_ninth_bit_q <= tx_ninth_bit_d;                 // see [RULE_03]
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            st1_q <= 8'hC0;                               // see [RULE_05] [RULE_08]
            break_flag_q <= 1'b0;
            break_armed_q <= 1'b1;
            rx_progress_flag_q <= 1'b0;
            idle_armed_q <= 1'b0;
            tx_pending_q <= 1'b0;
            ct1_q <= CT1_RESET;
            ct2_q <= CT2_RESET;
            err_ie_q <= CT3_IE_RESET;                     // see [RULE_04]
            ack_q <= 1'b0;
            rdat_q <= 32'h00000000;
        end else begin
            st1_q <= st1_d;
            break_flag_q <= break_flag_d;
            break_armed_q <= break_armed_d;
            rx_progress_flag_q <= rx_progress_flag_d;
            idle_armed_q <= idle_armed_d;
            tx_pending_q <= tx_pending_d;
            ct1_q <= ct1_d;
            ct2_q <= ct2_d;
            err_ie_q <= err_ie_d;
            ack_q <= ack_d;
            rdat_q <= rdat_d;
        end
    end
endmodule

// File: verification/assd_asserts.sv
`timescale 1ns/10ps
module assd_asserts
    import assd_pkg::*;
(
    input wire logic        sys_clk,
    input wire logic        rst_n,
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_we_i,
    input wire logic [9:0]  wb_adr_i,
    input wire logic [3:0]  wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic        wb_ack_o,
    input wire logic        tx_load,
    input wire logic        tx_load_ready,
    input wire logic [8:0]  tx_char,
    input wire logic        nine_bit_mode,
    input wire logic        tx_irq,
    input wire logic        rx_irq,
    input wire logic        err_irq
);
    logic wr;
    logic rd_st1;
    assign wr = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o;
    // Read data lags the live request lines
    assign rd_st1 = wb_ack_o && !wb_we_i && wb_adr_i[9:2] == IDX_STATUS_ONE;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    property p_ack_next; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o; endproperty
    a_ack_next: assert property (p_ack_next)
        else $error("ack missing one cycle after request");
    property p_ack_pulse; wb_ack_o |=> !wb_ack_o; endproperty
    a_ack_pulse: assert property (p_ack_pulse)
        else $error("ack longer than one cycle");
    property p_pad; wb_ack_o && !wb_we_i |-> wb_dat_o[31:8] == 24'h000000; endproperty
    a_pad: assert property (p_pad)
        else $error("upper read data not zero");
    property p_mode;
        wr && wb_sel_i[0] && wb_adr_i[9:2] == IDX_CONTROL_ONE
            |=> nine_bit_mode == wb_dat_i[CT1_NINE_BIT];
    endproperty
    a_mode: assert property (p_mode)
        else $error("character length output not following write");
    property p_load; tx_load |-> tx_load_ready; endproperty
    a_load: assert property (p_load)
        else $error("handoff while shifter not ready");
    property p_txchar; tx_load |=> $stable(tx_char); endproperty
    a_txchar: assert property (p_txchar)
        else $error("transmit word changed by handoff");
    property p_txirq; rd_st1 && tx_irq |-> wb_dat_o[7:6] != 2'b00; endproperty
    a_txirq: assert property (p_txirq)
        else $error("tx request without tx flag");
    property p_rxirq; rd_st1 && rx_irq |-> wb_dat_o[5:4] != 2'b00; endproperty
    a_rxirq: assert property (p_rxirq)
        else $error("rx request without rx flag");
    property p_errirq; rd_st1 && err_irq |-> wb_dat_o[3:0] != 4'h0; endproperty
    a_errirq: assert property (p_errirq)
        else $error("error request without error flag");
endmodule

// File: verification/assd_far_model.sv
`timescale 1ns/10ps
module assd_far_model (
    input wire logic       sys_clk,
    input wire logic       tx_load,
    input wire logic [8:0] tx_char,
    output logic           rx_char_done,
    output logic [8:0]     rx_char,
    output logic           rx_noise,
    output logic           rx_stop_zero,
    output logic           rx_parity_fail,
    output logic           rx_break,
    output logic           rx_enable_rise,
    output logic           rx_first_slot_zero,
    output logic           rx_false_start,
    output logic           rx_bit_tick,
    output logic           receive_pin,
    output logic           tx_load_ready,
    output logic           tx_busy,
    output logic           tx_queued
);
    logic       stall = 1'b0;
    logic [3:0] busy_n = 4'h0;
    logic [8:0] last_tx;
    assign tx_load_ready = !stall && busy_n == 4'h0;
    assign tx_busy = busy_n != 4'h0;
    initial begin
        {rx_char_done, rx_noise, rx_stop_zero, rx_parity_fail} = 4'h0;
        {rx_break, rx_enable_rise, rx_first_slot_zero, rx_false_start} = 4'h0;
        {rx_bit_tick, tx_queued} = 2'b00;
        rx_char = 9'h000;
        receive_pin = 1'b1;
    end
    // Busy outlasts a status poll
    always @(posedge sys_clk) begin
        tx_queued <= tx_load;
        if (tx_load) begin
            last_tx <= tx_char;
            busy_n <= 4'hC;
        end else if (busy_n != 4'h0) begin
            busy_n <= busy_n - 4'h1;
        end
    end
    task ev_char(input logic [8:0] c, input logic [2:0] q);
        @(posedge sys_clk);
        rx_char_done <= 1'b1;
        rx_char <= c;
        {rx_noise, rx_stop_zero, rx_parity_fail} <= q;
        @(posedge sys_clk);
        rx_char_done <= 1'b0;
        {rx_noise, rx_stop_zero, rx_parity_fail} <= 3'b000;
        rx_char <= ~c;
    endtask
    task strobe(input logic [3:0] m);
        @(posedge sys_clk);
        {rx_break, rx_enable_rise, rx_first_slot_zero, rx_false_start} <= m;
        @(posedge sys_clk);
        {rx_break, rx_enable_rise, rx_first_slot_zero, rx_false_start} <= 4'h0;
    endtask
    task bits(input int n, input logic v);
        repeat (n) begin
            @(posedge sys_clk);
            rx_bit_tick <= 1'b1;
            receive_pin <= v;
            @(posedge sys_clk);
            rx_bit_tick <= 1'b0;
        end
    endtask
endmodule

// File: verification/async_serial_status_data_tb.sv
`timescale 1ns/10ps
module async_serial_status_data_tb;
    import assd_pkg::*;
    logic        sys_clk, rst_n, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
    logic [9:0]  wb_adr_i;
    logic [3:0]  wb_sel_i;
    logic [31:0] wb_dat_i, wb_dat_o;
    logic        rx_char_done, rx_noise, rx_stop_zero, rx_parity_fail, rx_break;
    logic        rx_enable_rise, rx_first_slot_zero, rx_false_start, rx_bit_tick;
    logic        receive_pin, tx_load_ready, tx_busy, tx_queued, tx_load;
    logic        nine_bit_mode, tx_irq, rx_irq, err_irq;
    logic [8:0]  rx_char, tx_char;
    logic [7:0]  rv;
    int          miscompares = 0;
    int          cmp_count = 0;
    assd_top dut (.sys_clk, .rst_n, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
        .wb_dat_i, .wb_dat_o, .wb_ack_o, .rx_char_done, .rx_char, .rx_noise, .rx_stop_zero,
        .rx_parity_fail, .rx_break, .rx_enable_rise, .rx_first_slot_zero, .rx_false_start,
        .rx_bit_tick, .receive_pin, .tx_load_ready, .tx_busy, .tx_queued, .tx_load, .tx_char,
        .nine_bit_mode, .tx_irq, .rx_irq, .err_irq);
    assd_far_model far (.sys_clk, .tx_load, .tx_char, .rx_char_done, .rx_char, .rx_noise,
        .rx_stop_zero, .rx_parity_fail, .rx_break, .rx_enable_rise, .rx_first_slot_zero,
        .rx_false_start, .rx_bit_tick, .receive_pin, .tx_load_ready, .tx_busy, .tx_queued);
    initial begin
        sys_clk = 1'b0;
        forever #2 sys_clk = ~sys_clk;
    end
    task complete_run;
        $display("Comparisons %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            miscompares++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // No read-modify-write
    task automatic wb(input logic w, input logic [7:0] idx, input logic [7:0] d);
        int n;
        n = 0;
        @(posedge sys_clk);
        {wb_cyc_i, wb_stb_i, wb_we_i} <= {2'b11, w};
        wb_adr_i <= {idx, 2'b00};
        wb_dat_i <= {24'h000000, d};
        do begin
            @(posedge sys_clk);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 64);
        if (n >= 64) miscompares++;
        rv = wb_dat_o[7:0];
        {wb_cyc_i, wb_stb_i} <= 2'b00;
    endtask
    task rd(input logic [7:0] idx, input logic [7:0] exp, input string nm);
        wb(1'b0, idx, 8'h00);
        chk(nm, rv, exp);
    endtask
    initial begin
        {rst_n, wb_cyc_i, wb_stb_i, wb_we_i, wb_sel_i} = 8'h0F;
        {wb_adr_i, wb_dat_i} = '0;
        repeat (16) @(posedge sys_clk);
        rst_n <= 1'b1;
        rd(IDX_STATUS_ONE, 8'hC0, "status_one reset");
        rd(IDX_STATUS_TWO, 8'h00, "status_two reset");
        rd(IDX_CONTROL_TWO, 8'h00, "control_two reset");
        wb(1'b0, IDX_CONTROL_THREE, 8'h00);
        chk("error enables reset", rv[3:0], 4'h0);
        rd(8'h20, 8'h00, "unmapped");
        chk("irqs reset", {tx_irq, rx_irq, err_irq}, 3'b000);
        wb(1'b1, IDX_CONTROL_ONE, 8'h10);
        chk("nine_bit_mode", nine_bit_mode, 1'b1);
        far.stall <= 1'b1;
        wb(1'b1, IDX_CONTROL_TWO, 8'h80);
        chk("tx_irq empty", tx_irq, 1'b1);
        wb(1'b1, IDX_CONTROL_THREE, 8'h40);
        rd(IDX_STATUS_ONE, 8'hC0, "status_one armed");
        wb(1'b1, IDX_DATA_BUFFER, 8'h5A);
        rd(IDX_STATUS_ONE, 8'h00, "status_one pending");
        chk("tx_irq pending", tx_irq, 1'b0);
        chk("tx_char", tx_char, 9'h15A);
        far.stall <= 1'b0;
        repeat (3) @(posedge sys_clk);
        chk("shifted word", far.last_tx, 9'h15A);
        rd(IDX_STATUS_ONE, 8'h80, "status_one busy");
        repeat (16) @(posedge sys_clk);
        rd(IDX_STATUS_ONE, 8'hC0, "status_one done");
        wb(1'b1, IDX_CONTROL_TWO, 8'h40);
        chk("tx_irq complete", tx_irq, 1'b1);
        wb(1'b1, IDX_CONTROL_ONE, 8'h00);
        chk("nine_bit_mode off", nine_bit_mode, 1'b0);
        wb(1'b1, IDX_CONTROL_TWO, 8'h20);
        far.ev_char(9'h0A5, 3'b000);
        @(negedge sys_clk);
        chk("rx_irq full", rx_irq, 1'b1);
        wb(1'b0, IDX_CONTROL_THREE, 8'h00);
        chk("rx ninth copy", rv[7], 1'b1);
        rd(IDX_STATUS_ONE, 8'hE0, "status_one full");
        far.ev_char(9'h03C, 3'b000);
        rd(IDX_DATA_BUFFER, 8'hA5, "kept byte");
        rd(IDX_STATUS_ONE, 8'hC8, "overrun kept");
        wb(1'b1, IDX_CONTROL_THREE, 8'h08);
        chk("err_irq overrun", err_irq, 1'b1);
        rd(IDX_DATA_BUFFER, 8'hA5, "byte again");
        rd(IDX_STATUS_ONE, 8'hC0, "overrun cleared");
        for (int i = 0; i < 3; i++) begin
            wb(1'b1, IDX_CONTROL_THREE, 8'h04 >> i);
            far.ev_char(9'h011, 3'b100 >> i);
            @(negedge sys_clk);
            chk("err_irq gated on", err_irq, 1'b1);
            rd(IDX_STATUS_ONE, 8'hE0 | (8'h04 >> i), "error flag");
            wb(1'b1, IDX_CONTROL_THREE, 8'h00);
            chk("err_irq gated off", err_irq, 1'b0);
            rd(IDX_DATA_BUFFER, 8'h11, "error byte");
            rd(IDX_STATUS_ONE, 8'hC0, "error cleared");
        end
        wb(1'b1, IDX_CONTROL_ONE, 8'h10);
        far.ev_char(9'h13C, 3'b000);
        wb(1'b0, IDX_CONTROL_THREE, 8'h00);
        chk("rx ninth", rv[7], 1'b1);
        rd(IDX_STATUS_ONE, 8'hE0, "full nine");
        rd(IDX_DATA_BUFFER, 8'h3C, "byte nine");
        far.strobe(4'b1000);
        rd(IDX_STATUS_TWO, 8'h02, "break set");
        wb(1'b0, IDX_CONTROL_THREE, 8'h00);
        chk("rx ninth break", rv[7], 1'b0);
        rd(IDX_STATUS_ONE, 8'hE2, "break status_one");
        wb(1'b0, IDX_DATA_BUFFER, 8'h00);
        rd(IDX_STATUS_TWO, 8'h00, "break cleared");
        far.strobe(4'b1000);
        rd(IDX_STATUS_TWO, 8'h00, "break no rearm");
        far.bits(1, 1'b1);
        far.strobe(4'b1000);
        rd(IDX_STATUS_TWO, 8'h02, "break rearmed");
        wb(1'b0, IDX_STATUS_ONE, 8'h00);
        wb(1'b0, IDX_DATA_BUFFER, 8'h00);
        far.strobe(4'b0010);
        rd(IDX_STATUS_TWO, 8'h01, "progress set");
        far.strobe(4'b0001);
        rd(IDX_STATUS_TWO, 8'h00, "progress false start");
        wb(1'b1, IDX_CONTROL_ONE, 8'h00);
        wb(1'b1, IDX_CONTROL_TWO, 8'h10);
        far.strobe(4'b0100);
        far.bits(11, 1'b1);
        rd(IDX_STATUS_ONE, 8'hC0, "idle unarmed");
        far.ev_char(9'h055, 3'b000);
        far.bits(1, 1'b0);
        far.bits(9, 1'b1);
        rd(IDX_STATUS_ONE, 8'hE0, "idle nine ones");
        far.bits(1, 1'b1);
        rd(IDX_STATUS_ONE, 8'hF0, "idle ten ones");
        chk("rx_irq idle", rx_irq, 1'b1);
        rd(IDX_DATA_BUFFER, 8'h55, "idle byte");
        rd(IDX_STATUS_ONE, 8'hC0, "idle cleared");
        far.bits(11, 1'b1);
        rd(IDX_STATUS_ONE, 8'hC0, "idle needs char");
        wb_sel_i <= 4'hE;
        wb(1'b1, IDX_CONTROL_ONE, 8'h10);
        chk("sel ignored", nine_bit_mode, 1'b0);
        complete_run;
    end
    initial begin
        repeat (20000) @(posedge sys_clk);
        miscompares++;
        complete_run;
    end
endmodule
bind assd_top assd_asserts u_chk (.sys_clk, .rst_n, .wb_cyc_i, .wb_stb_i, .wb_we_i,
    .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .tx_load, .tx_load_ready,
    .tx_char, .nine_bit_mode, .tx_irq, .rx_irq, .err_irq);
